// ===== bench/ole_chk_sva.sv
// assertion checker for the overlay effect block bus and frame ports
`timescale 1ns/1ns
`default_nettype none
module ole_chk (
  input wire logic clock,
  input wire logic srst,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic vertical_sync_pulse,
  input wire ole_pkg::ole_layer_t layer
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence wr_take;
    s_awvalid && s_wvalid && s_awready && s_wready;
  endsequence
  sequence rd_take;
    s_arvalid && s_arready;
  endsequence
  AST_WR_ANSWER: assert property (wr_take |=> s_bvalid)
    else $error("write not answered next cycle");
  AST_RD_ANSWER: assert property (rd_take |=> s_rvalid)
    else $error("read not answered next cycle");
  AST_B_STANDS: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");
  AST_R_STANDS: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped early");
  AST_AW_W_PAIR: assert property (s_awready |-> s_wready && s_awvalid && s_wvalid && !s_bvalid)
    else $error("write channels taken apart or while busy");
  AST_AR_FREE: assert property (s_arready == !s_rvalid)
    else $error("read address ready wrong");
  AST_LAYER_HOLD: assert property (!vertical_sync_pulse |=> $stable(layer))
    else $error("layer changed without frame sync");
  AST_ENABLE_ALPHA: assert property (layer.enable == (layer.alpha != 7'h00))
    else $error("enable disagrees with alpha");
endmodule
bind ole_top ole_chk u_chk (.clock(clock), .srst(srst), .s_awvalid(s_awvalid),
  .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
  .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready),
  .s_rdata(s_rdata), .s_rvalid(s_rvalid), .s_rready(s_rready),
  .vertical_sync_pulse(vertical_sync_pulse), .layer(layer));
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the overlay effect block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0000_0000;
  logic [3:0] s_wstrb = 4'hF;
  logic vertical_sync_pulse = 1'b0;
  logic [1:0] main_rotation = 2'h0;
  logic [9:0] horizontal_active_pixels = 10'h000, vertical_active_lines = 10'h000;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  ole_pkg::ole_layer_t layer, exp_layer;
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  ole_pkg::ole_layer_t ly_q[$];
  logic vs_seen = 1'b0;
  int n_errors = 0, checked = 0;
  int seed = 32'h92e5f833;
  always #5 clock = ~clock;
  ole_top dut (.clock(clock), .srst(srst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .vertical_sync_pulse(vertical_sync_pulse), .main_rotation(main_rotation),
    .horizontal_active_pixels(horizontal_active_pixels),
    .vertical_active_lines(vertical_active_lines), .layer(layer));
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // the wr, rd and sync tasks open with an edge so back-to-back calls never re-drive in one step
  task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] resp);
    @(posedge clock);
    wr_q.push_back(resp);
    s_awaddr <= {idx, 2'b00};
    s_wdata <= {16'h0000, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do @(posedge clock); while (!s_awready);
    s_awvalid <= 1'b0;
    s_wvalid <= 1'b0;
    do @(posedge clock); while (!s_bvalid);
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] resp);
    @(posedge clock);
    rd_q.push_back({resp, 16'h0000, d});
    s_araddr <= {idx, 2'b00};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clock); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge clock); while (!s_rvalid);
    s_rready <= 1'b0;
  endtask
  task automatic sync(input int n);
    repeat (n) begin
      @(posedge clock);
      vertical_sync_pulse <= 1'b1;
      ly_q.push_back(exp_layer);
      @(posedge clock);
      vertical_sync_pulse <= 1'b0;
    end
  endtask
  task automatic step(input logic [6:0] a, input logic inv);
    exp_layer.alpha = a;
    exp_layer.invert = inv;
    exp_layer.enable = (a != 7'h00);
    sync(1);
  endtask
  always @(posedge clock) begin
    vs_seen <= vertical_sync_pulse && !srst;
    if (vs_seen) check(layer, ly_q.pop_front());
    if (s_bvalid && s_bready) check(s_bresp, wr_q.pop_front());
    if (s_rvalid && s_rready) check({s_rresp, s_rdata}, rd_q.pop_front());
  end
  initial begin
    #500000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    logic [9:0] regs[9];
    logic [15:0] msk[7];
    logic [15:0] v[7];
    regs = '{ole_pkg::IDX_FORMAT, ole_pkg::IDX_BASE_LO, ole_pkg::IDX_BASE_HI,
      ole_pkg::IDX_WIDTH, ole_pkg::IDX_HEIGHT, ole_pkg::IDX_X_ORIGIN, ole_pkg::IDX_Y_ORIGIN,
      ole_pkg::IDX_EFFECT, ole_pkg::IDX_ALPHA};
    // low start address bits kept clear, as software must
    msk = '{16'h001F, 16'hFFFC, 16'h0007, 16'h03FF, 16'h03FF, 16'h03FF, 16'h03FF};
    exp_layer = '0;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(regs[i], (i == 8) ? 16'h0040 : 16'h0000, 2'h0);
    rd(ole_pkg::IDX_MAIN_HEIGHT, 16'h0001, 2'h0);
    wr(ole_pkg::IDX_MAIN_HEIGHT, 16'h0155, 2'h0);
    rd(ole_pkg::IDX_MAIN_HEIGHT, 16'h0001, 2'h0);
    wr(10'h3FF, 16'hFFFF, ole_pkg::RESP_SLVERR);
    rd(10'h3FF, 16'h0000, ole_pkg::RESP_SLVERR);
    for (int i = 0; i < 7; i++) begin
      v[i] = 16'($random(seed)) & msk[i];
      wr(regs[i], v[i], 2'h0);
      rd(regs[i], v[i], 2'h0);
    end
    // upper lane only: clears bits 15:8 and leaves the low byte alone
    s_wstrb <= 4'h2;
    wr(ole_pkg::IDX_Y_ORIGIN, 16'h0000, 2'h0);
    s_wstrb <= 4'hF;
    v[6] = v[6] & 16'h00FF;
    rd(ole_pkg::IDX_Y_ORIGIN, v[6], 2'h0);
    wr(ole_pkg::IDX_EFFECT, 16'h0001, 2'h0);
    check(layer, 80'h0);
    exp_layer.rotation = v[0][4:3];
    exp_layer.depth = v[0][2:0];
    exp_layer.base_addr = {v[2][2:0], v[1]};
    exp_layer.width = v[3][9:0];
    exp_layer.height = v[4][9:0];
    exp_layer.x_origin = v[5][9:0];
    exp_layer.y_origin = v[6][9:0];
    step(7'h40, 1'b0);
    for (int k = 0; k < 8; k++) begin
      wr(ole_pkg::IDX_FORMAT, 16'({k[1:0], k[2:0]}), 2'h0);
      exp_layer.rotation = k[1:0];
      exp_layer.depth = k[2:0];
      sync(1);
    end
    for (int r = 0; r < 4; r++) begin
      main_rotation <= r[1:0];
      horizontal_active_pixels <= 10'($random(seed));
      vertical_active_lines <= 10'($random(seed));
      sync(2);
      rd(ole_pkg::IDX_MAIN_HEIGHT, 16'(r[0] ? horizontal_active_pixels
        : vertical_active_lines), 2'h0);
    end
    wr(ole_pkg::IDX_ALPHA, 16'h0025, 2'h0);
    step(7'h25, 1'b0);
    wr(ole_pkg::IDX_ALPHA, 16'h0107, 2'h0);
    wr(ole_pkg::IDX_EFFECT, 16'h0205, 2'h0);
    for (int i = 0; i < 9; i++) begin
      step((i < 8) ? 7'(2 * (i / 2)) : 7'h07, 1'b0);
      if (i == 3) rd(ole_pkg::IDX_EFFECT, 16'h020D, 2'h0);
    end
    rd(ole_pkg::IDX_EFFECT, 16'h0205, 2'h0);
    wr(ole_pkg::IDX_ALPHA, 16'h0307, 2'h0);
    wr(ole_pkg::IDX_EFFECT, 16'h0004, 2'h0);
    step(7'h07, 1'b0);
    step(7'h00, 1'b0);
    step(7'h00, 1'b0);
    rd(ole_pkg::IDX_EFFECT, 16'h0004, 2'h0);
    wr(ole_pkg::IDX_EFFECT, 16'h0000, 2'h0);
    step(7'h00, 1'b0);
    wr(ole_pkg::IDX_EFFECT, 16'h0202, 2'h0);
    for (int i = 0; i < 5; i++) step(((i / 2) % 2) ? 7'h00 : 7'h07, 1'b0);
    rd(ole_pkg::IDX_EFFECT, 16'h020A, 2'h0);
    wr(ole_pkg::IDX_EFFECT, 16'h0001, 2'h0);
    step(7'h07, 1'b0);
    wr(ole_pkg::IDX_EFFECT, 16'h0003, 2'h0);
    for (int i = 0; i < 4; i++) step(7'h07, i[0]);
    wr(ole_pkg::IDX_EFFECT, 16'h0001, 2'h0);
    step(7'h07, 1'b0);
    wr(ole_pkg::IDX_ALPHA, 16'h0208, 2'h0);
    wr(ole_pkg::IDX_EFFECT, 16'h0006, 2'h0);
    for (int i = 0; i < 4; i++) step(7'(4 * ((i < 2) ? 2 - i : i - 2)), 1'b0);
    wr(ole_pkg::IDX_EFFECT, 16'h0000, 2'h0);
    step(7'h00, 1'b0);
    wr(ole_pkg::IDX_EFFECT, 16'h0006, 2'h0);
    for (int i = 0; i < 4; i++) step(7'(4 * ((i < 3) ? i : 4 - i)), 1'b0);
    rd(ole_pkg::IDX_EFFECT, 16'h000E, 2'h0);
    wr(ole_pkg::IDX_EFFECT, 16'h0000, 2'h0);
    step(7'h00, 1'b0);
    wr(ole_pkg::IDX_EFFECT, 16'h0007, 2'h0);
    step(7'h00, 1'b0);
    wr(ole_pkg::IDX_ALPHA, 16'h0002, 2'h0);
    wr(ole_pkg::IDX_EFFECT, 16'h0005, 2'h0);
    for (int i = 0; i < 4; i++) step(7'((i < 2) ? i : 2), 1'b0);
    repeat (5) @(posedge clock);
    check(rd_q.size() + wr_q.size() + ly_q.size(), 80'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== verilog/ole_pkg.sv
// shared constants and types for the overlay layer effect block
package ole_pkg;

  localparam int ADDR_W = 12;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_MAIN_HEIGHT = 10'h048;
  localparam logic [9:0] IDX_FORMAT = 10'h050;
  localparam logic [9:0] IDX_BASE_LO = 10'h052;
  localparam logic [9:0] IDX_BASE_HI = 10'h054;
  localparam logic [9:0] IDX_WIDTH = 10'h056;
  localparam logic [9:0] IDX_HEIGHT = 10'h058;
  localparam logic [9:0] IDX_X_ORIGIN = 10'h05A;
  localparam logic [9:0] IDX_Y_ORIGIN = 10'h05C;
  localparam logic [9:0] IDX_EFFECT = 10'h060;
  localparam logic [9:0] IDX_ALPHA = 10'h062;

  // field positions
  localparam int FMT_DEPTH_LSB = 0;
  localparam int FMT_ROT_LSB = 3;
  localparam int EFF_SEL_LSB = 0;
  localparam int EFF_STATUS_BIT = 3;
  localparam int EFF_PERIOD_LSB = 9;
  localparam int ALPHA_RATIO_LSB = 0;
  localparam int ALPHA_STEP_LSB = 8;

  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [6:0] RST_RATIO = 7'h40;
  localparam logic [9:0] RST_MAIN_HEIGHT = 10'h001;

  localparam logic [6:0] ALPHA_ZERO = 7'h00;
  localparam logic [6:0] ALPHA_ONE = 7'h01;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OLE_FX_BLANK = 3'b000,
    OLE_FX_NORMAL = 3'b001,
    OLE_FX_ALPHA_TOGGLE = 3'b010,
    OLE_FX_INVERT_TOGGLE = 3'b011,
    OLE_FX_FADE_OUT = 3'b100,
    OLE_FX_FADE_IN = 3'b101,
    OLE_FX_FADE_CONT = 3'b110,
    OLE_FX_RESERVED = 3'b111
  } ole_effect_t;

  // settings handed to the display engine, frame aligned
  typedef struct packed {
    logic [1:0] rotation;
    logic [2:0] depth;
    logic [18:0] base_addr;
    logic [9:0] width;
    logic [9:0] height;
    logic [9:0] x_origin;
    logic [9:0] y_origin;
    logic [6:0] alpha;
    logic invert;
    logic enable;
  } ole_layer_t;

endpackage

// ===== verilog/ole_top.sv
// overlay layer register file, frame latching and blink/fade effect engine
`timescale 1ns/1ns
`default_nettype none
module ole_top (
  input wire logic clock,
  input wire logic srst,
  input wire logic [ole_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [ole_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic vertical_sync_pulse,
  input wire logic [1:0] main_rotation,
  input wire logic [9:0] horizontal_active_pixels,
  input wire logic [9:0] vertical_active_lines,
  output ole_pkg::ole_layer_t layer
);

  // software-side copies
  logic [1:0] rot_r;
  logic [2:0] depth_r;
  logic [15:0] base_lo_r;
  logic [2:0] base_hi_r;
  logic [9:0] width_r;
  logic [9:0] height_r;
  logic [9:0] x_org_r;
  logic [9:0] y_org_r;
  logic [6:0] period_r;
  ole_pkg::ole_effect_t effect_r;
  logic [1:0] step_r;
  logic [6:0] ratio_r;
  logic [9:0] main_height_r;

  // effect engine
  ole_pkg::ole_effect_t fx_prev_r;
  logic [6:0] frame_cnt_r;
  logic [6:0] frame_cnt_nxt;
  logic [6:0] alpha_r;
  logic [6:0] alpha_nxt;
  logic phase_r;
  logic phase_nxt;
  logic dir_up_r;
  logic dir_up_nxt;
  logic busy_r;
  logic busy_nxt;

  // bus
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;
  logic rd_fire;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic [15:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = d[7:0];
    end
    if (strb[1]) begin
      res[15:8] = d[15:8];
    end
    return res;
  endfunction

  // default read word for unmapped indices, and write word for unmapped and read-only indices
  localparam logic [15:0] RST16 = ole_pkg::RST_ZERO;

  logic [15:0] wmerged;

  // ---------------- write channel ----------------
  // address and data are taken together; a lone half waits for its partner
  assign wr_fire = s_awvalid && s_wvalid && !bvalid_r;
  assign s_awready = wr_fire;
  assign s_wready = wr_fire;
  assign wr_idx = s_awaddr[ole_pkg::ADDR_W-1:2];

  always_comb begin
    wr_hit = 1'b1;
    case (wr_idx)
      ole_pkg::IDX_FORMAT: wmerged = merge16({11'h000, rot_r, depth_r}, s_wdata, s_wstrb);
      ole_pkg::IDX_BASE_LO: wmerged = merge16(base_lo_r, s_wdata, s_wstrb);
      ole_pkg::IDX_BASE_HI: wmerged = merge16({13'h0000, base_hi_r}, s_wdata, s_wstrb);
      ole_pkg::IDX_WIDTH: wmerged = merge16({6'h00, width_r}, s_wdata, s_wstrb);
      ole_pkg::IDX_HEIGHT: wmerged = merge16({6'h00, height_r}, s_wdata, s_wstrb);
      ole_pkg::IDX_X_ORIGIN: wmerged = merge16({6'h00, x_org_r}, s_wdata, s_wstrb);
      ole_pkg::IDX_Y_ORIGIN: wmerged = merge16({6'h00, y_org_r}, s_wdata, s_wstrb);
      ole_pkg::IDX_EFFECT: wmerged = merge16({period_r, 6'h00, effect_r}, s_wdata, s_wstrb);
      ole_pkg::IDX_ALPHA: wmerged = merge16({6'h00, step_r, 1'b0, ratio_r}, s_wdata, s_wstrb);
      ole_pkg::IDX_MAIN_HEIGHT: begin
        wmerged = RST16;
      end
      default: begin
        wmerged = RST16;
        wr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rot_r <= 2'h0;
      depth_r <= 3'h0;
      base_lo_r <= ole_pkg::RST_ZERO;
      base_hi_r <= 3'h0;
      width_r <= 10'h000;
      height_r <= 10'h000;
      x_org_r <= 10'h000;
      y_org_r <= 10'h000;
      period_r <= 7'h00;
      effect_r <= ole_pkg::OLE_FX_BLANK;
      step_r <= 2'h0;
      ratio_r <= ole_pkg::RST_RATIO;
    end else if (wr_fire) begin
      case (wr_idx)
        ole_pkg::IDX_FORMAT: begin
          rot_r <= wmerged[ole_pkg::FMT_ROT_LSB +: 2];
          depth_r <= wmerged[ole_pkg::FMT_DEPTH_LSB +: 3];
        end
        // alignment bits are stored as written; software keeps them clear
        ole_pkg::IDX_BASE_LO: base_lo_r <= wmerged;
        ole_pkg::IDX_BASE_HI: base_hi_r <= wmerged[2:0];
        ole_pkg::IDX_WIDTH: width_r <= wmerged[9:0];
        ole_pkg::IDX_HEIGHT: height_r <= wmerged[9:0];
        ole_pkg::IDX_X_ORIGIN: x_org_r <= wmerged[9:0];
        ole_pkg::IDX_Y_ORIGIN: y_org_r <= wmerged[9:0];
        ole_pkg::IDX_EFFECT: begin
          period_r <= wmerged[ole_pkg::EFF_PERIOD_LSB +: 7];
          effect_r <= ole_pkg::ole_effect_t'(wmerged[ole_pkg::EFF_SEL_LSB +: 3]);
        end
        ole_pkg::IDX_ALPHA: begin
          step_r <= wmerged[ole_pkg::ALPHA_STEP_LSB +: 2];
          ratio_r <= wmerged[ole_pkg::ALPHA_RATIO_LSB +: 7];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      bvalid_r <= 1'b0;
      bresp_r <= ole_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? ole_pkg::RESP_OKAY : ole_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_bvalid = bvalid_r;
  assign s_bresp = bresp_r;

  // ---------------- read channel ----------------
  assign rd_fire = s_arvalid && !rvalid_r;
  assign s_arready = !rvalid_r;
  assign rd_idx = s_araddr[ole_pkg::ADDR_W-1:2];

  always_comb begin
    rd_hit = 1'b1;
    case (rd_idx)
      ole_pkg::IDX_MAIN_HEIGHT: rd_word = {6'h00, main_height_r};
      ole_pkg::IDX_FORMAT: rd_word = {11'h000, rot_r, depth_r};
      ole_pkg::IDX_BASE_LO: rd_word = base_lo_r;
      ole_pkg::IDX_BASE_HI: rd_word = {13'h0000, base_hi_r};
      ole_pkg::IDX_WIDTH: rd_word = {6'h00, width_r};
      ole_pkg::IDX_HEIGHT: rd_word = {6'h00, height_r};
      ole_pkg::IDX_X_ORIGIN: rd_word = {6'h00, x_org_r};
      ole_pkg::IDX_Y_ORIGIN: rd_word = {6'h00, y_org_r};
      ole_pkg::IDX_EFFECT: rd_word = {period_r, 5'h00, busy_r, effect_r};
      ole_pkg::IDX_ALPHA: rd_word = {6'h00, step_r, 1'b0, ratio_r};
      default: begin
        rd_word = RST16;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= ole_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= {16'h0000, rd_word};
      rresp_r <= rd_hit ? ole_pkg::RESP_OKAY : ole_pkg::RESP_SLVERR;
    end else if (s_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = rresp_r;

  // ---------------- main height readback ----------------
  // sampled once per frame, so a size change shows after the next frame sync
  always_ff @(posedge clock) begin
    if (srst) begin
      main_height_r <= ole_pkg::RST_MAIN_HEIGHT;
    end else if (vertical_sync_pulse) begin
      main_height_r <= main_rotation[0] ? horizontal_active_pixels
                                        : vertical_active_lines;
    end
  end

  // ---------------- effect engine ----------------
  logic entering;
  logic period_hit;
  logic [6:0] step_val;
  logic [6:0] alpha_dn;
  logic [6:0] alpha_up;

  // step read live so a running fade picks it up at once
  assign step_val = ole_pkg::ALPHA_ONE << step_r;
  assign entering = (effect_r != fx_prev_r);
  assign period_hit = (frame_cnt_r >= period_r);

  // clamped steps; uneven step never overshoots
  assign alpha_dn = (alpha_r > step_val) ? alpha_r - step_val : ole_pkg::ALPHA_ZERO;
  assign alpha_up = (alpha_r >= ratio_r || (ratio_r - alpha_r) <= step_val) ? ratio_r
                    : alpha_r + step_val;

  always_comb begin
    frame_cnt_nxt = (entering || period_hit) ? 7'h00 : frame_cnt_r + 7'h01;
    alpha_nxt = alpha_r;
    phase_nxt = phase_r;
    dir_up_nxt = dir_up_r;
    busy_nxt = 1'b0;
    case (effect_r)
      ole_pkg::OLE_FX_NORMAL: begin
        alpha_nxt = ratio_r;
        phase_nxt = 1'b0;
      end
      ole_pkg::OLE_FX_ALPHA_TOGGLE, ole_pkg::OLE_FX_INVERT_TOGGLE: begin
        busy_nxt = 1'b1;
        alpha_nxt = ratio_r;
        if (entering) begin
          phase_nxt = 1'b0;
        end else if (period_hit) begin
          phase_nxt = !phase_r;
        end
      end
      ole_pkg::OLE_FX_FADE_OUT: begin
        phase_nxt = 1'b0;
        if (entering) begin
          alpha_nxt = ratio_r;
          busy_nxt = (ratio_r != ole_pkg::ALPHA_ZERO);
        end else if (period_hit) begin
          alpha_nxt = alpha_dn;
          busy_nxt = (alpha_dn != ole_pkg::ALPHA_ZERO);
        end else begin
          busy_nxt = busy_r;
        end
      end
      ole_pkg::OLE_FX_FADE_IN: begin
        phase_nxt = 1'b0;
        if (entering) begin
          alpha_nxt = ole_pkg::ALPHA_ZERO;
          busy_nxt = (ratio_r != ole_pkg::ALPHA_ZERO);
        end else if (period_hit) begin
          alpha_nxt = alpha_up;
          busy_nxt = (alpha_up != ratio_r);
        end else begin
          busy_nxt = busy_r;
        end
      end
      ole_pkg::OLE_FX_FADE_CONT: begin
        busy_nxt = 1'b1;
        phase_nxt = 1'b0;
        if (entering) begin
          dir_up_nxt = (fx_prev_r == ole_pkg::OLE_FX_BLANK);
          alpha_nxt = (fx_prev_r == ole_pkg::OLE_FX_BLANK) ? ole_pkg::ALPHA_ZERO : ratio_r;
        end else if (period_hit) begin
          if (dir_up_r) begin
            alpha_nxt = alpha_up;
            dir_up_nxt = (alpha_up != ratio_r);
          end else begin
            alpha_nxt = alpha_dn;
            dir_up_nxt = (alpha_dn == ole_pkg::ALPHA_ZERO);
          end
        end
      end
      default: begin
        // blank and the reserved code hide the overlay
        alpha_nxt = ole_pkg::ALPHA_ZERO;
        phase_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fx_prev_r <= ole_pkg::OLE_FX_BLANK;
      frame_cnt_r <= 7'h00;
      alpha_r <= ole_pkg::ALPHA_ZERO;
      phase_r <= 1'b0;
      dir_up_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (vertical_sync_pulse) begin
      fx_prev_r <= effect_r;
      frame_cnt_r <= frame_cnt_nxt;
      alpha_r <= alpha_nxt;
      phase_r <= phase_nxt;
      dir_up_r <= dir_up_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ---------------- frame-aligned layer settings ----------------
  logic [6:0] out_alpha;
  assign out_alpha = (effect_r == ole_pkg::OLE_FX_ALPHA_TOGGLE && phase_nxt)
                     ? ole_pkg::ALPHA_ZERO : alpha_nxt;

  always_ff @(posedge clock) begin
    if (srst) begin
      layer <= '0;
    end else if (vertical_sync_pulse) begin
      layer.rotation <= rot_r;
      layer.depth <= depth_r;
      layer.base_addr <= {base_hi_r, base_lo_r};
      layer.width <= width_r;
      layer.height <= height_r;
      layer.x_origin <= x_org_r;
      layer.y_origin <= y_org_r;
      layer.alpha <= out_alpha;
      // inverted data is still blended at the live alpha
      layer.invert <= (effect_r == ole_pkg::OLE_FX_INVERT_TOGGLE) && phase_nxt;
      layer.enable <= (out_alpha != ole_pkg::ALPHA_ZERO);
    end
  end

endmodule
`default_nettype wire
